// [src/fpi_regs.svh]
// register offsets, bit positions and reset values of the fifo port and event flag bank
// assumes byte-wide registers reached over the serial port, five address bits
`ifndef FPI_REGS_SVH
`define FPI_REGS_SVH

`define FPI_ADDR_W       5
`define FPI_OFF_CHAN_A   5'h00
`define FPI_OFF_CHAN_B   5'h01
`define FPI_OFF_FLAGS    5'h02
`define FPI_OFF_MASK     5'h03

`define FPI_BIT_FAULT    7
`define FPI_BIT_WAKE     6
`define FPI_BIT_SEND0    4
`define FPI_BIT_RECV0    2
`define FPI_BIT_AVAIL0   0

`define FPI_FLAGS_RST    8'h00
`define FPI_MASK_RST     8'h00
`define FPI_FLAGS_ROC    8'hfc
`define FPI_BYTE_ZERO    8'h00

`define FPI_CMD_RD_BIT   7
`define FPI_LAST_BIT     3'h7
`define FPI_FIRST_BIT    3'h0

`endif

// [src/fpi_pkg.sv]
// types shared by the fifo port and event flag bank
// assumes the constants of fpi_regs.svh are included where needed
package fpi_pkg;

	// per-channel configuration bits held elsewhere in the device
	typedef struct packed {
		logic framer_on;
		logic whole_msg_mode;
		logic avail_pin_on;
		logic fault_pin_on;
	} fpi_chan_cfg_s;

	// one byte on a valid/ready stream
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} fpi_byte_s;

	// receive queue entry, hdr marks the length byte
	typedef struct packed {
		logic       hdr;
		logic [7:0] data;
	} fpi_entry_s;

	typedef enum logic [1:0] {
		FPI_IDLE,
		FPI_CMD,
		FPI_DATA
	} fpi_spi_state_e;

endpackage

// [src/fpi_top.sv]
// fifo data ports, event flags, mask and indicator pins of a two-channel link master
// assumes a serial host on sclk/cs_n/mosi/miso (mode 0, msb first), framers on clk_i
`timescale 1ns/1ns
`include "fpi_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// flip-flop fifo, depth a power of two
module fpi_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	input  wire logic         clk_i,
	input  wire logic         resetn_i,
	input  wire logic         flush_i,
	input  wire logic         in_valid_i,
	input  wire logic [W-1:0] in_data_i,
	output logic              in_ready_o,
	output logic              out_valid_o,
	output logic [W-1:0]      out_data_o,
	input  wire logic         out_ready_i
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0]   cnt;
	wire           push = in_valid_i & in_ready_o;
	wire           pop  = out_valid_o & out_ready_i;

	// full and empty straight from the count
	assign in_ready_o  = (cnt != D[AW:0]);
	assign out_valid_o = (cnt != '0);
	assign out_data_o  = mem[rd_ptr];

	// pointers and count; flush drops everything
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			cnt    <= '0;
		end else if (flush_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			cnt    <= '0;
		end else begin
			wr_ptr <= wr_ptr + AW'(push);
			rd_ptr <= rd_ptr + AW'(pop);
			cnt    <= cnt + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// storage needs no reset
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end
endmodule // fpi_fifo

////////////////////////////////////////////////////////////////////////////////
module fpi_top #(
	parameter int DEPTH = 16
) (
	input  wire logic                     clk_i,
	input  wire logic                     resetn_i,
	input  wire logic                     spi_sclk_i,
	input  wire logic                     spi_cs_n_i,
	input  wire logic                     spi_mosi_i,
	output logic                          spi_miso_o,
	output logic                          spi_miso_oe_o,
	input  wire fpi_pkg::fpi_chan_cfg_s [1:0] cfg_i,
	output fpi_pkg::fpi_byte_s [1:0]      tx_o,
	input  wire logic [1:0]               tx_ready_i,
	input  wire fpi_pkg::fpi_byte_s [1:0] rx_i,
	output logic [1:0]                    rx_ready_o,
	input  wire logic [1:0]               rx_start_i,
	input  wire logic [1:0][7:0]          rx_len_i,
	input  wire logic [1:0]               frame_ok_i,
	input  wire logic [3:0]               fault_event_i,
	input  wire logic                     wakeup_done_i,
	input  wire logic [1:0]               send_fault_i,
	input  wire logic [1:0]               recv_fault_i,
	output logic                          irq_n_o,
	output logic                          chan_a_fault_out_o,
	output logic                          chan_b_fault_out_o,
	output logic                          chan_a_avail_out_o,
	output logic                          chan_b_avail_out_o,
	output logic [1:0][7:0]               recv_level_o
);
	import fpi_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// pin synchronisers: first stage feeds only the second
	logic sclk_q1, sclk_q2, sclk_q3;
	logic cs_q1, cs_q2;
	logic mosi_q1, mosi_q2;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			{sclk_q1, sclk_q2, sclk_q3} <= 3'h0;
			{cs_q1, cs_q2}              <= 2'h3;
			{mosi_q1, mosi_q2}          <= 2'h0;
		end else begin
			{sclk_q1, sclk_q2, sclk_q3} <= {spi_sclk_i, sclk_q1, sclk_q2};
			{cs_q1, cs_q2}              <= {spi_cs_n_i, cs_q1};
			{mosi_q1, mosi_q2}          <= {spi_mosi_i, mosi_q1};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// serial frame engine state
	fpi_spi_state_e           state;
	fpi_spi_state_e           next_state;
	logic [2:0]               bit_cnt;
	logic [7:0]               shift_in;
	logic [7:0]               shift_out;
	logic                     is_rd;
	logic [`FPI_ADDR_W-1:0]   addr;
	logic [7:0]               rd_snap;    // value last loaded for readout
	logic [7:0]               flags;
	logic [7:0]               next_flags;
	logic [7:0]               mask;

	// edge and access decode
	wire       sel       = ~cs_q2;
	wire       rise      = sclk_q2 & ~sclk_q3 & sel;
	wire       fall      = ~sclk_q2 & sclk_q3 & sel;
	wire       byte_done = rise & (bit_cnt == `FPI_LAST_BIT);
	wire [7:0] byte_in   = {shift_in[6:0], mosi_q2};
	wire       in_data   = (state == FPI_DATA);
	wire       wr_stb    = byte_done & in_data & ~is_rd;
	// a readout is committed only once the host clocks its first bit,
	// so the look-ahead load at a burst's end costs no queue byte
	wire       rd_commit = rise & in_data & is_rd & (bit_cnt == `FPI_FIRST_BIT);
	wire       load_rd   = byte_done & (state == FPI_CMD ? byte_in[`FPI_CMD_RD_BIT] : is_rd);
	wire [`FPI_ADDR_W-1:0] load_addr = (state == FPI_CMD) ? byte_in[`FPI_ADDR_W-1:0] : addr;

	// per-channel queue views
	fpi_entry_s [1:0] rx_head;
	logic [1:0]       rx_has;
	logic [1:0]       avail_set;
	logic [1:0]       port_rd;

	// next frame state: cs high always returns to idle
	always_comb begin
		next_state = state;
		unique case (state)
			FPI_IDLE: if (sel) next_state = FPI_CMD;
			FPI_CMD:  if (byte_done) next_state = FPI_DATA;
			FPI_DATA: next_state = FPI_DATA;
		endcase
		if (!sel) next_state = FPI_IDLE;
	end

	// read mux over the four mapped offsets, others read zero
	// reading empty queue
	wire [7:0] rd_a = (cfg_i[0].framer_on & rx_has[0]) ? rx_head[0].data : `FPI_BYTE_ZERO;
	wire [7:0] rd_b = (cfg_i[1].framer_on & rx_has[1]) ? rx_head[1].data : `FPI_BYTE_ZERO;
	wire [7:0] rdata = (load_addr == `FPI_OFF_CHAN_A) ? rd_a :
	                   (load_addr == `FPI_OFF_CHAN_B) ? rd_b :
	                   (load_addr == `FPI_OFF_FLAGS)  ? flags :
	                   (load_addr == `FPI_OFF_MASK)   ? mask : `FPI_BYTE_ZERO;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state    <= FPI_IDLE;
			bit_cnt  <= `FPI_FIRST_BIT;
			shift_in <= `FPI_BYTE_ZERO;
			is_rd    <= 1'b0;
			addr     <= `FPI_OFF_CHAN_A;
		end else begin
			state <= next_state;
			if (!sel) begin
				bit_cnt <= `FPI_FIRST_BIT;
			end else if (rise) begin
				bit_cnt  <= bit_cnt + 3'h1;
				shift_in <= byte_in;
			end
			if (byte_done && state == FPI_CMD) begin
				is_rd <= byte_in[`FPI_CMD_RD_BIT];
				addr  <= byte_in[`FPI_ADDR_W-1:0];
			end
		end
	end

	// readout shift: load at byte end, shift on falls inside the byte
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			shift_out     <= `FPI_BYTE_ZERO;
			rd_snap       <= `FPI_BYTE_ZERO;
			spi_miso_oe_o <= 1'b0;
		end else begin
			spi_miso_oe_o <= sel;
			if (load_rd) begin
				shift_out <= rdata;
				rd_snap   <= rdata;
			end else if (fall && bit_cnt != `FPI_FIRST_BIT) begin
				shift_out <= {shift_out[6:0], 1'b0};
			end
		end
	end
	assign spi_miso_o = shift_out[7];

	////////////////////////////////////////////////////////////////////////////
	// channel queues
	for (genvar c = 0; c < 2; c++) begin : g_chan
		localparam logic [`FPI_ADDR_W-1:0] PORT = (c == 0) ? `FPI_OFF_CHAN_A : `FPI_OFF_CHAN_B;
		logic       hdr_pend;
		logic [7:0] hdr_byte;
		logic [7:0] level;
		logic       rx_in_ready;
		logic       rx_push;
		fpi_entry_s rx_in;
		wire on    = cfg_i[c].framer_on;
		wire flush = ~on;
		// host write queues send byte; full queue drops it
		fpi_fifo #(.W(8), .D(DEPTH)) u_send (
			.clk_i       (clk_i),
			.resetn_i    (resetn_i),
			.flush_i     (flush),
			.in_valid_i  (wr_stb & (addr == PORT) & on),
			.in_data_i   (byte_in),
			.in_ready_o  (),
			.out_valid_o (tx_o[c].valid),
			.out_data_o  (tx_o[c].data),
			.out_ready_i (tx_ready_i[c])
		);

		// length byte ahead of the message
		assign rx_in         = {hdr_pend, hdr_pend ? hdr_byte : rx_i[c].data};
		assign rx_ready_o[c] = rx_in_ready & ~hdr_pend & on;
		assign rx_push       = on & rx_in_ready & (hdr_pend | rx_i[c].valid);
		assign port_rd[c]    = rd_commit & (addr == PORT);

		fpi_fifo #(.W($bits(fpi_entry_s)), .D(DEPTH)) u_recv (
			.clk_i       (clk_i),
			.resetn_i    (resetn_i),
			.flush_i     (flush),
			.in_valid_i  (on & (hdr_pend | rx_i[c].valid)),
			.in_data_i   (rx_in),
			.in_ready_o  (rx_in_ready),
			.out_valid_o (rx_has[c]),
			.out_data_o  (rx_head[c]),
			.out_ready_i (port_rd[c] & on)
		);

		assign avail_set[c] = cfg_i[c].whole_msg_mode ? frame_ok_i[c] : (rx_push & ~rx_has[c]);
		wire lvl_up = rx_push & ~hdr_pend;
		wire lvl_dn = port_rd[c] & on & rx_has[c] & ~rx_head[c].hdr;
		always_ff @(posedge clk_i or negedge resetn_i) begin
			if (!resetn_i) begin
				hdr_pend <= 1'b0;
				hdr_byte <= `FPI_BYTE_ZERO;
				level    <= `FPI_BYTE_ZERO;
			end else if (flush) begin
				hdr_pend <= 1'b0;
				level    <= `FPI_BYTE_ZERO;
			end else begin
				if (rx_start_i[c]) begin
					hdr_pend <= 1'b1;
					hdr_byte <= rx_len_i[c];
				end else if (rx_push) begin
					hdr_pend <= 1'b0;
				end
				level <= level + 8'(lvl_up) - 8'(lvl_dn);
			end
		end
		assign recv_level_o[c] = level;
	end

	////////////////////////////////////////////////////////////////////////////
	// event flags: set beats clear; a flags read clears only bits seen by the host,
	// so an event landing between load and commit survives
	logic [7:0] set_vec;
	logic [7:0] clr_vec;
	always_comb begin
		set_vec = `FPI_FLAGS_RST;
		clr_vec = `FPI_FLAGS_RST;
		set_vec[`FPI_BIT_FAULT] = |fault_event_i;
		set_vec[`FPI_BIT_WAKE] = wakeup_done_i;
		for (int c = 0; c < 2; c++) begin
			set_vec[`FPI_BIT_SEND0 + c]  = send_fault_i[c];
			set_vec[`FPI_BIT_RECV0 + c]  = recv_fault_i[c];
			set_vec[`FPI_BIT_AVAIL0 + c] = avail_set[c];
			clr_vec[`FPI_BIT_AVAIL0 + c] = port_rd[c];
		end
		// clear on read of bits 7..2
		if (rd_commit && addr == `FPI_OFF_FLAGS) begin
			clr_vec = clr_vec | (rd_snap & `FPI_FLAGS_ROC);
		end
	end
	assign next_flags = (flags & ~clr_vec) | set_vec;

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			flags <= `FPI_FLAGS_RST;
		end else begin
			flags <= next_flags;
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mask <= `FPI_MASK_RST;
		end else if (wr_stb && addr == `FPI_OFF_MASK) begin
			mask <= byte_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// output pins, all registered
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			irq_n_o            <= 1'b1;
			chan_a_fault_out_o <= 1'b0;
			chan_b_fault_out_o <= 1'b0;
			chan_a_avail_out_o <= 1'b0;
			chan_b_avail_out_o <= 1'b0;
		end else begin
			irq_n_o <= ~|(flags & mask);
			chan_a_fault_out_o <= cfg_i[0].fault_pin_on & flags[`FPI_BIT_RECV0];
			chan_b_fault_out_o <= cfg_i[1].fault_pin_on & flags[`FPI_BIT_RECV0 + 1];
			chan_a_avail_out_o <= cfg_i[0].avail_pin_on & flags[`FPI_BIT_AVAIL0];
			chan_b_avail_out_o <= cfg_i[1].avail_pin_on & flags[`FPI_BIT_AVAIL0 + 1];
		end
	end
endmodule // fpi_top

// [verif/fpi_top_properties.sv]
// port level timing checks of the fifo port and event flag bank
// assumes it is bound into fpi_top and sees only that module's ports
`timescale 1ns/1ns
module fpi_top_properties #(
	parameter int DEPTH = 16
) (
	input wire logic                         clk_i,
	input wire logic                         resetn_i,
	input wire logic                         spi_cs_n_i,
	input wire logic                         spi_miso_oe_o,
	input wire fpi_pkg::fpi_chan_cfg_s [1:0] cfg_i,
	input wire fpi_pkg::fpi_byte_s [1:0]     tx_o,
	input wire logic [1:0]                   rx_ready_o,
	input wire logic [1:0]                   rx_start_i,
	input wire logic [1:0]                   frame_ok_i,
	input wire logic [1:0]                   recv_fault_i,
	input wire logic                         irq_n_o,
	input wire logic                         chan_a_fault_out_o,
	input wire logic                         chan_b_fault_out_o,
	input wire logic                         chan_a_avail_out_o,
	input wire logic                         chan_b_avail_out_o,
	input wire logic [1:0][7:0]              recv_level_o
);
	import fpi_pkg::*;
	// one clock domain, reset disables everything
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	////////////////////////////////////////////////////////////////////////////////
	// pins lag their flag by two registers at most
	a_fault_pin_a: assert property (
		recv_fault_i[0] && cfg_i[0].fault_pin_on |-> ##[1:3] chan_a_fault_out_o)
		else $error("fault pin A did not follow its flag");
	a_fault_pin_gate: assert property (
		chan_b_fault_out_o |-> $past(cfg_i[1].fault_pin_on))
		else $error("fault pin B high without its pin enable");
	a_avail_pin_gate: assert property (
		chan_a_avail_out_o |-> $past(cfg_i[0].avail_pin_on))
		else $error("avail pin A high without its pin enable");
	a_avail_first_word: assert property (
		rx_start_i[0] && cfg_i[0].framer_on && cfg_i[0].avail_pin_on
		&& !cfg_i[0].whole_msg_mode && recv_level_o[0] == 8'h00
		|-> ##[1:6] chan_a_avail_out_o)
		else $error("avail A not raised by first word");
	a_whole_msg_avail: assert property (
		frame_ok_i[1] && cfg_i[1].whole_msg_mode && cfg_i[1].avail_pin_on
		|-> ##[1:3] chan_b_avail_out_o)
		else $error("avail B not raised by good frame");
	// a queue flushed by framer off shows nothing
	a_framer_off_idle: assert property (
		!cfg_i[1].framer_on && $past(!cfg_i[1].framer_on) |-> !tx_o[1].valid && !rx_ready_o[1])
		else $error("queue B active with framer off");
	a_len_slot_first: assert property (
		rx_start_i[0] && cfg_i[0].framer_on |=> !rx_ready_o[0])
		else $error("length byte slot not reserved");
	a_miso_oe_idle: assert property (
		spi_cs_n_i [*4] |-> !spi_miso_oe_o)
		else $error("readout driven outside a frame");
	// main scenarios
	c_msg_start: cover property (rx_start_i[0] ##[1:6] chan_a_avail_out_o);
	c_whole_msg: cover property (frame_ok_i[1] && cfg_i[1].whole_msg_mode);
	c_irq_fall: cover property ($fell(irq_n_o));
endmodule // fpi_top_properties

bind fpi_top fpi_top_properties #(.DEPTH(DEPTH)) chk_u (
	.clk_i(clk_i), .resetn_i(resetn_i), .spi_cs_n_i(spi_cs_n_i),
	.spi_miso_oe_o(spi_miso_oe_o), .cfg_i(cfg_i), .tx_o(tx_o), .rx_ready_o(rx_ready_o),
	.rx_start_i(rx_start_i), .frame_ok_i(frame_ok_i), .recv_fault_i(recv_fault_i),
	.irq_n_o(irq_n_o), .chan_a_fault_out_o(chan_a_fault_out_o),
	.chan_b_fault_out_o(chan_b_fault_out_o), .chan_a_avail_out_o(chan_a_avail_out_o),
	.chan_b_avail_out_o(chan_b_avail_out_o), .recv_level_o(recv_level_o));

// [verif/fpi_spi_host.sv]
// serial host model that reaches the register port in mode 0, msb first
// assumes clk_i is the device clock; link edges move four clocks apart
`timescale 1ns/1ns
module fpi_spi_host (
	input  wire logic clk_i,
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      mosi_o,
	input  wire logic miso_i
);
	// link clock stands low between frames
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	// half a link period, 80 ns
	task automatic half();
		repeat (4) @(posedge clk_i);
		#1;
	endtask
	task automatic open_frame();
		cs_n_o = 1'b0;
		half();
	endtask
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			mosi_o = tx[i];
			half();
			sclk_o = 1'b1;
			rx[i] = miso_i;
			half();
			sclk_o = 1'b0;
		end
	endtask
	// idle data line flips so a stale bit is never mistaken for data
	task automatic close_frame();
		half();
		cs_n_o = 1'b1;
		mosi_o = ~mosi_o;
		half();
	endtask
endmodule // fpi_spi_host

// [verif/fpi_top_tb_top.sv]
// self-checking bench of the fifo ports, event flags, mask and pins
// assumes the serial host model and the bound checker are compiled alongside
`timescale 1ns/1ns
`include "fpi_regs.svh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
	$display("Error %s expected %h seen %h", n, e, g); end end
module fpi_top_tb_top;
	import fpi_pkg::*;
	logic                clk_i = 1'b0;
	logic                resetn_i = 1'b0;
	logic                sclk, cs_n, mosi, miso, miso_oe, irq_n, fa, fb, aa, ab;
	fpi_chan_cfg_s [1:0] cfg;
	fpi_byte_s [1:0]     tx, rx;
	logic [1:0]          tx_rdy, rx_rdy, rx_start, frame_ok;
	logic [1:0][7:0]     rx_len, level;
	logic [8:0]          ev;
	logic [7:0]          r;
	int                  miscompares = 0;
	int                  n_compared = 0;
	int                  cycles = 0;
	// undriven readout line toggles so it never looks valid
	wire miso_w = miso_oe ? miso : ~sclk;
	fpi_top #(.DEPTH(16)) dut_u (
		.clk_i(clk_i), .resetn_i(resetn_i), .spi_sclk_i(sclk), .spi_cs_n_i(cs_n),
		.spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .cfg_i(cfg),
		.tx_o(tx), .tx_ready_i(tx_rdy), .rx_i(rx), .rx_ready_o(rx_rdy),
		.rx_start_i(rx_start), .rx_len_i(rx_len), .frame_ok_i(frame_ok),
		.fault_event_i(ev[3:0]), .wakeup_done_i(ev[4]), .send_fault_i(ev[6:5]),
		.recv_fault_i(ev[8:7]), .irq_n_o(irq_n), .chan_a_fault_out_o(fa),
		.chan_b_fault_out_o(fb), .chan_a_avail_out_o(aa), .chan_b_avail_out_o(ab),
		.recv_level_o(level));
	fpi_spi_host host_u (.clk_i(clk_i), .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
		.miso_i(miso_w));
	////////////////////////////////////////////////////////////////////////////////
	always #10 clk_i = ~clk_i;
	// hang guard, a few times the expected run
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			conclude();
		end
	end
	task automatic conclude();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	task automatic rd(input logic [4:0] a, output logic [7:0] d);
		logic [7:0] x;
		host_u.open_frame();
		host_u.xfer({3'b100, a}, x);
		host_u.xfer(8'h00, d);
		host_u.close_frame();
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [7:0] x;
		host_u.open_frame();
		host_u.xfer({3'b000, a}, x);
		host_u.xfer(d, x);
		host_u.close_frame();
	endtask
	// framer side byte, held until the queue takes it
	task automatic push(input int c, input logic [7:0] d);
		rx[c] = {1'b1, d};
		while (rx_rdy[c] !== 1'b1)
			wt(1);
		wt(1);
		rx[c].valid = 1'b0;
	endtask
	// two byte message announced by its length
	task automatic msg(input int c, input logic [7:0] d0);
		rx_start[c] = 1'b1;
		rx_len[c] = 8'h02;
		wt(1);
		rx_start[c] = 1'b0;
		push(c, d0);
		push(c, d0 + 8'h01);
	endtask
	task automatic drain(input int c, input logic [7:0] d0);
		logic [7:0] x;
		host_u.open_frame();
		host_u.xfer({3'b100, 5'(c)}, x);
		// stop at the last stored byte
		for (int i = 0; i < 3; i++) begin
			host_u.xfer(8'h00, x);
			`CHK("rx", (i == 0) ? 8'h02 : d0 + 8'(i - 1), x)
		end
		host_u.close_frame();
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		cfg = 8'hbb;
		{tx_rdy, rx, rx_start, frame_ok, rx_len, ev} = '0;
		wt(10);
		resetn_i = 1'b1;
		wt(4);
		rd(`FPI_OFF_FLAGS, r);
		`CHK("flags", `FPI_FLAGS_RST, r)
		rd(`FPI_OFF_MASK, r);
		`CHK("mask", `FPI_MASK_RST, r)
		rd(5'h1f, r);
		`CHK("unmapped", 8'h00, r)
		// every event source, then clear on read
		for (int k = 0; k < 9; k++) begin
			ev[k] = 1'b1;
			wt(1);
			ev[k] = 1'b0;
			wt(3);
			`CHK("pins", (k == 7) ? 2'b01 : (k == 8) ? 2'b10 : 2'b00, {fb, fa})
			rd(`FPI_OFF_FLAGS, r);
			`CHK("flag", 8'h01 << ((k < 4) ? 7 : (k == 4) ? 6 : (k < 7) ? k - 1 : k - 5), r)
			rd(`FPI_OFF_FLAGS, r);
			`CHK("cleared", 8'h00, r)
		end
		// pin enable off keeps the fault pin low while the flag still sets
		cfg[0].fault_pin_on = 1'b0;
		ev[7] = 1'b1;
		wt(1);
		ev[7] = 1'b0;
		wt(3);
		`CHK("pin_off", 1'b0, fa)
		rd(`FPI_OFF_FLAGS, r);
		`CHK("flag_off", 8'h04, r)
		cfg[0].fault_pin_on = 1'b1;
		// mask lets only the wake flag reach the request line
		wr(`FPI_OFF_MASK, 8'h40);
		rd(`FPI_OFF_MASK, r);
		`CHK("mask", 8'h40, r)
		wr(`FPI_OFF_FLAGS, 8'hff);
		ev[5] = 1'b1;
		wt(1);
		ev[5] = 1'b0;
		wt(3);
		`CHK("irq_n", 1'b1, irq_n)
		ev[4] = 1'b1;
		wt(1);
		ev[4] = 1'b0;
		wt(3);
		`CHK("irq_n", 1'b0, irq_n)
		rd(`FPI_OFF_FLAGS, r);
		`CHK("flags", 8'h50, r)
		wt(3);
		`CHK("irq_n", 1'b1, irq_n)
		// burst one past full while the framer stalls, then drain
		for (int c = 0; c < 2; c++) begin
			host_u.open_frame();
			host_u.xfer(8'(c), r);
			for (int i = 0; i < 17; i++)
				host_u.xfer(8'h30 + 8'(i), r);
			host_u.close_frame();
			tx_rdy[c] = 1'b1;
			for (int i = 0; i < 16; i++) begin
				`CHK("tx", {1'b1, 8'h30 + 8'(i)}, tx[c])
				wt(1);
			end
			`CHK("tx_empty", 1'b0, tx[c].valid)
			tx_rdy[c] = 1'b0;
		end
		cfg[1].framer_on = 1'b0;
		wt(2);
		wr(`FPI_OFF_CHAN_B, 8'h55);
		`CHK("tx_off", 1'b0, tx[1].valid)
		`CHK("rx_off", 1'b0, rx_rdy[1])
		cfg[1].framer_on = 1'b1;
		// default mode on A
		msg(0, 8'ha0);
		wt(3);
		`CHK("level", 8'h02, level[0])
		`CHK("avail_pin", 1'b1, aa)
		rd(`FPI_OFF_FLAGS, r);
		`CHK("avail", 8'h01, r)
		rd(`FPI_OFF_FLAGS, r);
		`CHK("avail_kept", 8'h01, r)
		drain(0, 8'ha0);
		wt(3);
		rd(`FPI_OFF_FLAGS, r);
		`CHK("avail_clr", 8'h00, r)
		`CHK("avail_pin", 1'b0, aa)
		// whole message mode on B
		cfg[1].whole_msg_mode = 1'b1;
		msg(1, 8'hb0);
		wt(3);
		`CHK("early_pin", 1'b0, ab)
		frame_ok[1] = 1'b1;
		wt(1);
		frame_ok[1] = 1'b0;
		wt(3);
		`CHK("msg_pin", 1'b1, ab)
		`CHK("level_b", 8'h02, level[1])
		rd(`FPI_OFF_FLAGS, r);
		`CHK("msg_flag", 8'h02, r)
		drain(1, 8'hb0);
		conclude();
	end
endmodule // fpi_top_tb_top
